/* hw/pin_route_cell.sv */
// One remappable pin: registered choice between a peripheral and the port
`timescale 1ns/1ps
`default_nettype none
module pin_route_cell #(
   parameter int FUNC_COUNT = 64
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] sel,
   input wire logic [63:0] periph_out,
   input wire logic [63:0] periph_drive,
   input wire logic gpio_out,
   input wire logic gpio_drive_n,
   output logic pin_out,
   output logic pin_oe_n
);
   // Selector decode
   wire logic use_periph;
   wire logic pin_out_next;
   wire logic pin_oe_n_next;

   assign use_periph = pin_select_pkg::sel_names_func(sel, FUNC_COUNT);
   // R3 - route chosen function
   // R8 - fall back to port
   assign pin_out_next = use_periph ? periph_out[sel] : gpio_out;
   assign pin_oe_n_next = use_periph ? ~periph_drive[sel] : gpio_drive_n;

   // Output flops, released pin after reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         pin_out <= pin_out_next;
         pin_oe_n <= pin_oe_n_next;
      end
   end

   // Sampled reset_n keeps the release edge from starting an attempt
   a_route_periph_pin: assert property ( // R3
      @(posedge clk) disable iff (!reset_n)
      reset_n && pin_select_pkg::sel_names_func(sel, FUNC_COUNT)
      |=> (pin_out == $past(periph_out[sel])) && (pin_oe_n == !$past(periph_drive[sel])))
      else $error("Mapped pin does not follow its peripheral");

   a_gpio_default_pin: assert property ( // R8
      @(posedge clk) disable iff (!reset_n)
      reset_n && !pin_select_pkg::sel_names_func(sel, FUNC_COUNT)
      |=> (pin_out == $past(gpio_out)) && (pin_oe_n == $past(gpio_drive_n)))
      else $error("Unmapped pin does not follow the port");
endmodule
`default_nettype wire

/* hw/pin_select_pkg.sv */
// Constants and helpers shared by the remappable output pin selector
package pin_select_pkg;
   // Register port geometry
   localparam int ADDR_W = 3;                  // Word index width
   localparam int DATA_W = 16;                 // Register width
   localparam int REG_COUNT = 7;               // Selector registers in the bank
   localparam int PIN_COUNT = 14;              // Remappable pins handled here
   localparam int FIRST_PIN = 14;              // Number of the lowest pin
   // Register word indexes
   localparam logic [2:0] OUT_PIN_SELECT_PAIR_14_15 = 3'h0;
   localparam logic [2:0] OUT_PIN_SELECT_PAIR_16_17 = 3'h1;
   localparam logic [2:0] OUT_PIN_SELECT_PAIR_18_19 = 3'h2;
   localparam logic [2:0] OUT_PIN_SELECT_PAIR_20_21 = 3'h3;
   localparam logic [2:0] OUT_PIN_SELECT_PAIR_22_23 = 3'h4;
   localparam logic [2:0] OUT_PIN_SELECT_PAIR_24_25 = 3'h5;
   localparam logic [2:0] OUT_PIN_SELECT_PAIR_26_27 = 3'h6;
   // Field layout
   localparam int FIELD_W = 6;                 // Selector field width
   localparam int EVEN_LSB = 0;                // Even pin field, bits 5-0
   localparam int ODD_LSB = 8;                 // Odd pin field, bits 13-8
   localparam int SMALL_PKG_FIELD = 1;         // Field index of pin 15
   localparam int FUNC_SPACE = 64;             // Function numbers a field can name
   // Reset values
   localparam logic [5:0] FIELD_RESET = 6'h00;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   localparam logic [5:0] SEL_GPIO = 6'h00;    // Pin stays with its port

   // True when a selector names an existing peripheral function
   function automatic logic sel_names_func(input logic [5:0] sel, input int func_count);
      sel_names_func = (sel != SEL_GPIO) && (int'(sel) < func_count);
   endfunction
endpackage

/* hw/remappable_output_pin_select.sv */
// Selector register bank and output steering for remappable pins 14 to 27
//
// Summary of operation
// R1 - Upper field picks odd pin's function
// R2 - Lower field picks even pin's function
// R3 - Field value n routes function n
// R4 - Bits 15,14,7,6 ignore writes, read zero
// R5 - Power-on reset clears every selector bit
// R6 - Selector bits read back last write
// R7 - Small package: pin 15 field absent
// R8 - Zero or unknown value keeps port control
//
`timescale 1ns/1ps
`default_nettype none
module remappable_output_pin_select #(
   parameter int FUNC_COUNT = 64,     // Function numbers below this exist
   parameter bit SMALL_PACKAGE = 1'b0 // Smaller package variant
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata,
   input wire logic [63:0] periph_out,
   input wire logic [63:0] periph_drive,
   input wire logic [13:0] gpio_out,
   input wire logic [13:0] gpio_drive_n,
   output logic [13:0] remap_pin_out,
   output logic [13:0] remap_pin_oe_n
);
   // Selector fields, index k is pin 14+k
   logic [5:0] field_reg [0:13];
   // Read data register
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   // Address decode
   wire logic addr_hit;
   wire logic [3:0] even_idx;
   wire logic [3:0] odd_idx;
   wire logic [5:0] read_even;
   wire logic [5:0] read_odd;
   wire logic [15:0] read_word;

   assign addr_hit = (int'(addr) < pin_select_pkg::REG_COUNT);
   assign even_idx = {addr, 1'b0};
   assign odd_idx = {addr, 1'b1};
   // Out of range address 7 reads zero through the addr_hit guard below
   assign read_even = addr_hit ? field_reg[even_idx] : pin_select_pkg::FIELD_RESET;
   assign read_odd = addr_hit ? field_reg[odd_idx] : pin_select_pkg::FIELD_RESET;
   // R4 - unimplemented bits zero
   assign read_word = {2'b00, read_odd, 2'b00, read_even};
   // Data only in the cycle after a read strobe
   assign rdata_next = rd_stb ? read_word : pin_select_pkg::RDATA_RESET;

   // Field storage, one write process per field
   genvar k;
   generate
      for (k = 0; k < pin_select_pkg::PIN_COUNT; k = k + 1) begin : g_field
         localparam logic [2:0] MY_ADDR = 3'(k / 2);
         localparam bit IS_ODD = (k % 2) == 1;
         localparam bit ABSENT = SMALL_PACKAGE && (k == pin_select_pkg::SMALL_PKG_FIELD);
         wire logic [5:0] field_next;
         wire logic field_we;
         // R1 - odd pin from upper byte
         // R2 - even pin from lower byte
         assign field_next = IS_ODD ? wdata[13:8] : wdata[5:0];
         // R6 - software writes field
         // R7 - absent field never written
         assign field_we = wr_stb && (addr == MY_ADDR) && !ABSENT;
         // R5 - cleared at power-on reset
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               field_reg[k] <= pin_select_pkg::FIELD_RESET;
            end else if (field_we) begin
               field_reg[k] <= field_next;
            end
         end
         // Steering cell for this pin
         pin_route_cell #(
            .FUNC_COUNT(FUNC_COUNT)
         ) u_cell (
            .clk(clk),
            .reset_n(reset_n),
            .sel(field_reg[k]),
            .periph_out(periph_out),
            .periph_drive(periph_drive),
            .gpio_out(gpio_out[k]),
            .gpio_drive_n(gpio_drive_n[k]),
            .pin_out(remap_pin_out[k]),
            .pin_oe_n(remap_pin_oe_n[k])
         );
      end
   endgenerate

   // Read data flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= pin_select_pkg::RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign rdata = rdata_reg;

   // Helper: write then read of the same register
   sequence s_write_then_read;
      (wr_stb && addr_hit) ##1 (rd_stb && (addr == $past(addr)));
   endsequence

   a_odd_field_read: assert property ( // R1
      @(posedge clk) disable iff (!reset_n)
      (rd_stb && addr_hit) |=> (rdata[13:8] == $past(read_odd)))
      else $error("Upper byte does not show the odd pin field");

   a_even_field_write: assert property ( // R2
      @(posedge clk) disable iff (!reset_n)
      (wr_stb && addr_hit) |=> (field_reg[$past(even_idx)] == $past(wdata[5:0])))
      else $error("Lower byte not stored in the even pin field");

   a_route_follows_sel: assert property ( // R3
      @(posedge clk) disable iff (!reset_n)
      reset_n && pin_select_pkg::sel_names_func(field_reg[0], FUNC_COUNT)
      |=> (remap_pin_out[0] == $past(periph_out[field_reg[0]])))
      else $error("Pin 14 does not carry its selected function");

   a_unimpl_bits_zero: assert property ( // R4
      @(posedge clk) disable iff (!reset_n)
      (rdata[15:14] == 2'b00) && (rdata[7:6] == 2'b00))
      else $error("Unimplemented bits read nonzero");

   a_reset_clears_all: assert property ( // R5
      @(posedge clk)
      !reset_n |-> (field_reg[0] == 6'h00) && (field_reg[13] == 6'h00)
      && (remap_pin_oe_n == 14'h3fff))
      else $error("Selectors not cleared by reset");

   a_write_read_back: assert property ( // R6
      @(posedge clk) disable iff (!reset_n)
      s_write_then_read |=> (rdata[5:0] == $past(wdata[5:0], 2))
      && (rdata[13:8] == (($past(addr, 2) == 3'h0 && SMALL_PACKAGE) ? 6'h00 : $past(wdata[13:8], 2))))
      else $error("Read does not return the last write");

   a_small_pin15_absent: assert property ( // R7
      @(posedge clk) disable iff (!reset_n)
      SMALL_PACKAGE |-> (field_reg[1] == 6'h00))
      else $error("Pin 15 field exists in small package");

   a_zero_keeps_port: assert property ( // R8
      @(posedge clk) disable iff (!reset_n)
      reset_n && (field_reg[13] == 6'h00) |=> (remap_pin_out[13] == $past(gpio_out[13])))
      else $error("Unmapped pin 27 left port control");

   a_read_only_once: assert property ( // R6
      @(posedge clk) disable iff (!reset_n)
      !rd_stb |=> (rdata == 16'h0000))
      else $error("Read data outside the answer cycle");
endmodule
`default_nettype wire

/* tb/tb_remappable_output_pin_select.sv */
// Testbench for the remappable output pin selector, full and small package
`timescale 1ns/1ps
`default_nettype none
module tb_remappable_output_pin_select;
   localparam int FUNCS = 40; // Short list, selectors 40..63 name nothing
   logic clk = 1'b0;
   logic reset_n = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [63:0] periph_out = 64'h0000_0000_0000_0000;
   logic [63:0] periph_drive = 64'h0000_0000_0000_0000;
   logic [13:0] gpio_out = 14'h2a5a; // Port data pattern
   logic [13:0] gpio_drive_n = 14'h1234; // Port enable pattern
   logic [15:0] rdata, rdata_small;
   logic [13:0] pin_out, pin_oe_n, small_out, small_oe_n;
   int n_mismatch = 0;
   int n_checks = 0;
   // Full package instance
   remappable_output_pin_select #(.FUNC_COUNT(FUNCS), .SMALL_PACKAGE(1'b0))
      i_remappable_output_pin_select (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .periph_out(periph_out), .periph_drive(periph_drive), .gpio_out(gpio_out),
      .gpio_drive_n(gpio_drive_n), .remap_pin_out(pin_out), .remap_pin_oe_n(pin_oe_n));
   // Small package instance, same stimulus
   remappable_output_pin_select #(.FUNC_COUNT(FUNCS), .SMALL_PACKAGE(1'b1))
      i_remappable_output_pin_select_small (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata_small),
      .periph_out(periph_out), .periph_drive(periph_drive), .gpio_out(gpio_out),
      .gpio_drive_n(gpio_drive_n), .remap_pin_out(small_out), .remap_pin_oe_n(small_oe_n));
   // Clock at 200 MHz
   always #2.5 clk = ~clk;
   // Compare and count
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle write, called at an edge; strobe left up for a following write
   task automatic write_reg(input logic [2:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
   endtask
   // One-cycle read, called at an edge; data taken mid answer cycle
   task automatic read_reg(input logic [2:0] a, output logic [15:0] big, output logic [15:0] sm);
      addr <= a;
      wr_stb <= 1'b0;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      big = rdata;
      sm = rdata_small;
      @(posedge clk);
   endtask
   // Selector for pin k in a routing pass
   function automatic logic [5:0] sel_of(input int k, input int shift);
      sel_of = 6'((k * 5 + shift) % 64);
   endfunction
   // All words read zero and all full package pins follow the port after reset
   task automatic check_reset();
      logic [15:0] b, s;
      @(negedge clk);
      chk("pin_out", {2'b00, gpio_out}, {2'b00, pin_out});
      chk("pin_oe_n", {2'b00, gpio_drive_n}, {2'b00, pin_oe_n});
      @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         read_reg(3'(i), b, s);
         chk("reset word", 16'h0000, b);
         chk("small reset word", 16'h0000, s);
      end
   endtask
   // Set every bit, only the fields stay
   task automatic check_bits();
      logic [15:0] b, s;
      for (int i = 0; i < 8; i++) begin
         write_reg(3'(i), 16'hffff);
         read_reg(3'(i), b, s);
         chk("word", (i == 7) ? 16'h0000 : 16'h3f3f, b);
         chk("small word", (i == 7) ? 16'h0000 : (i == 0) ? 16'h003f : 16'h3f3f, s);
      end
   endtask
   // Program all selectors, then compare every pin
   task automatic check_routing(input logic [63:0] pat, input int shift);
      logic [13:0] eo, ee, so, se;
      logic [5:0] v;
      @(posedge clk);
      periph_out <= pat;
      periph_drive <= ~pat;
      gpio_out <= ~gpio_out;
      for (int i = 0; i < 7; i++) begin
         write_reg(3'(i), {2'b00, sel_of(2 * i + 1, shift), 2'b00, sel_of(2 * i, shift)});
      end
      wr_stb <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      for (int k = 0; k < 14; k++) begin
         v = sel_of(k, shift);
         eo[k] = (v != 6'h00 && int'(v) < FUNCS) ? pat[v] : gpio_out[k];
         // Drive request is ~pat, so the active-low enable shows pat
         ee[k] = (v != 6'h00 && int'(v) < FUNCS) ? pat[v] : gpio_drive_n[k];
         so[k] = (k == 1) ? gpio_out[k] : eo[k];
         se[k] = (k == 1) ? gpio_drive_n[k] : ee[k];
      end
      chk("pin_out", {2'b00, eo}, {2'b00, pin_out});
      chk("pin_oe_n", {2'b00, ee}, {2'b00, pin_oe_n});
      chk("small pin_out", {2'b00, so}, {2'b00, small_out});
      chk("small pin_oe_n", {2'b00, se}, {2'b00, small_oe_n});
   endtask
   // Report and finish
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      check_reset();
      check_bits();
      check_routing(64'h5a3c_96e1_0f7b_c42d, 0);
      check_routing(64'ha5c3_691e_f084_3bd2, 39);
      close_out();
   end
endmodule
`default_nettype wire
